// >>> pkg/tpp_pkg.sv
// Constants, field layouts and carrier types of the programmable pulse timer.
package tpp_pkg;

  // ************************************************************
  // Register map (word addresses on the plain register port)
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_DUTY = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_STATE = 4'h6;

  // ************************************************************
  // Field positions of timer_one_control, interrupt and state registers
  // ************************************************************
  localparam int CTL_START_LSB = 0;
  localparam int CTL_REPEAT_BIT = 2;
  localparam int CTL_PRESET_BIT = 3;
  localparam int CTL_MODE_BIT = 4;
  localparam int CTL_CLK_LSB = 5;
  localparam int INT_MATCH_BIT = 0;
  localparam int STATE_FLOP_BIT = 0;
  localparam int STATE_RUN_BIT = 1;
  localparam int STATE_ARMED_BIT = 2;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_COMMAND = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;
  localparam logic MODE_TIMER = 1'h0;
  localparam logic MODE_PULSE = 1'h1;
  localparam logic [15:0] RST_COMPARE = 16'hffff;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ************************************************************
  // Timing: source clock dividers and trigger noise filter
  // ************************************************************
  localparam int PRESCALE_W = 7;
  localparam logic [6:0] DIV_MASK_0 = 7'h00;
  localparam logic [6:0] DIV_MASK_1 = 7'h07;
  localparam logic [6:0] DIV_MASK_2 = 7'h1f;
  localparam logic [6:0] DIV_MASK_3 = 7'h7f;
  localparam int TRIG_REJECT_FC = 4;
  localparam int TRIG_ACCEPT_CYCLES = TRIG_REJECT_FC + 1;
  localparam int FILT_W = 3;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tpp_bus_req_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic mode;
    logic preset;
    logic repeat_sel;
    logic [1:0] start;
  } tpp_control_t;

endpackage : tpp_pkg

// >>> src/tpp_prescaler.sv
// Source clock tick generator for the pulse timer counter.
`timescale 1ns/10ps
`default_nettype none
module tpp_prescaler
  import tpp_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [1:0] clk_sel, // Divider select.
  output logic tick // One-cycle source clock pulse.
);

  logic [PRESCALE_W-1:0] div_count;
  logic [PRESCALE_W-1:0] mask;

  always_comb begin
    case (clk_sel)
      2'h0: mask = DIV_MASK_0;
      2'h1: mask = DIV_MASK_1;
      2'h2: mask = DIV_MASK_2;
      default: mask = DIV_MASK_3;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 7'h01;
    end
  end

  // The divider free runs, so the first tick after a start may come early by up to one period.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= ((div_count & mask) == mask);
    end
  end

endmodule : tpp_prescaler
`default_nettype wire

// >>> src/tpp_trigger_filter.sv
// Synchroniser, noise filter and edge detector for the trigger pin.
`timescale 1ns/10ps
`default_nettype none
module tpp_trigger_filter
  import tpp_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic trigger_input_pin, // Asynchronous trigger pin.
  output logic rise, // One-cycle pulse on a clean rising edge.
  output logic fall // One-cycle pulse on a clean falling edge.
);

  logic sync_a;
  logic sync_b;
  logic level;
  logic [FILT_W-1:0] stable;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= trigger_input_pin;
      sync_b <= sync_a;
    end
  end

  // A new level is taken only after it has held for more than the rejection width.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stable <= '0;
      level <= 1'b0;
    end else if (sync_b == level) begin
      stable <= '0;
    end else if (stable == FILT_W'(TRIG_ACCEPT_CYCLES - 1)) begin // see [RULE_17]
      stable <= '0;
      level <= sync_b;
    end else begin
      stable <= stable + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= (sync_b != level) && sync_b && (stable == FILT_W'(TRIG_ACCEPT_CYCLES - 1));
      fall <= (sync_b != level) && !sync_b && (stable == FILT_W'(TRIG_ACCEPT_CYCLES - 1));
    end
  end

endmodule : tpp_trigger_filter
`default_nettype wire

// >>> src/tpp_timer.sv
// Sixteen-bit timer in programmable pulse generation mode with its register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RULE_01] Counter advances on selected source clock
// [RULE_02] Start field picks trigger edge or command
// [RULE_03] Repeat bit: 0 continuous, 1 one-shot
// [RULE_04] Duty match toggles, interrupts, keeps counting
// [RULE_05] Period match toggles, interrupts, clears, continues
// [RULE_06] Start field 00 stops, pin holds
// [RULE_07] One-shot period match clears start, stops
// [RULE_08] Pin is complement of output flop
// [RULE_09] Reset clears output flop
// [RULE_10] Software writes compares above current count
// [RULE_11] Software leaves preset alone while running
// [RULE_12] Inverted stop makes preset load complemented
// [RULE_13] Timer mode then pulse mode reinitialises
// [RULE_14] Software keeps period above duty
// [RULE_15] Duty written only after pulse mode
// [RULE_16] Start field picks rising or falling edge
// [RULE_17] Trigger filter rejects short noise pulses
// [RULE_18] Sixteen-bit counter, exact equality compares
// [RULE_19] Match interrupt is one pulse per match
module tpp_timer
  import tpp_pkg::*;
(
  input wire logic ref_clk, // System clock, 125 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire tpp_bus_req_t bus_req, // Register port request.
  output logic [DATA_W-1:0] rd_data, // Read data, valid the cycle after rd.
  input wire logic trigger_input_pin, // External trigger pin.
  output logic pulse_output_pin, // Pulse pin, inverse of the output flop.
  output logic timer_match_interrupt, // One-cycle pulse per compare match.
  output logic irq // Level interrupt from unmasked status.
);

  // ************************************************************
  // State
  // ************************************************************
  tpp_control_t ctrl;
  logic [15:0] period_compare;
  logic [15:0] duty_compare;
  logic [15:0] count;
  logic output_flipflop;
  logic phase;
  logic running;
  logic int_status;
  logic int_mask;
  logic tick;
  logic trig_rise;
  logic trig_fall;
  logic trig_hit;
  logic duty_hit;
  logic period_hit;
  logic match;
  logic ctl_write;
  logic next_flop;

  function automatic logic hit(input tpp_bus_req_t req, input logic [3:0] a);
    hit = req.wr && (req.addr == a);
  endfunction : hit

  // ************************************************************
  // Helpers
  // ************************************************************
  tpp_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_sel(ctrl.clk_sel),
    .tick(tick)
  );

  tpp_trigger_filter u_trigger (
    .ref_clk(ref_clk),
    .reset(reset),
    .trigger_input_pin(trigger_input_pin),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  assign ctl_write = hit(bus_req, ADDR_CONTROL);
  assign trig_hit = ((ctrl.start == START_RISE) && trig_rise) ||
                    ((ctrl.start == START_FALL) && trig_fall); // see [RULE_16]
  assign duty_hit = running && tick && (count == duty_compare); // see [RULE_18]
  assign period_hit = running && tick && (count == period_compare); // see [RULE_18]
  assign match = duty_hit || period_hit;

  // ************************************************************
  // Control and compare registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= '0;
    end else if (ctl_write) begin
      ctrl <= tpp_control_t'(bus_req.wdata[6:0]);
    end else if (period_hit && ctrl.repeat_sel) begin
      ctrl.start <= START_STOP; // see [RULE_07]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period_compare <= RST_COMPARE;
      duty_compare <= RST_COMPARE;
    end else begin
      if (hit(bus_req, ADDR_PERIOD)) begin
        period_compare <= bus_req.wdata;
      end
      if (hit(bus_req, ADDR_DUTY)) begin
        duty_compare <= bus_req.wdata;
      end
    end
  end

  // ************************************************************
  // Run control and counter
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      running <= 1'b0;
    end else if (ctrl.mode != MODE_PULSE || ctrl.start == START_STOP) begin
      running <= 1'b0; // see [RULE_06]
    end else if (period_hit && ctrl.repeat_sel) begin
      running <= 1'b0; // see [RULE_07] [RULE_03]
    end else if (!running) begin
      running <= (ctrl.start == START_COMMAND) || trig_hit; // see [RULE_02]
    end
  end

  // The count is left where it stopped; a new start continues from zero only after a clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= RST_WORD;
    end else if (ctrl.mode != MODE_PULSE) begin
      count <= RST_WORD;
    end else if (period_hit) begin
      count <= RST_WORD; // see [RULE_05]
    end else if (running && tick) begin
      count <= count + 16'h0001; // see [RULE_01] [RULE_04]
    end
  end

  // ************************************************************
  // Output flop
  // ************************************************************
  // The phase bit remembers an odd number of toggles since the last initialisation,
  // which is why a preset written after such a stop lands inverted.
  always_comb begin
    next_flop = output_flipflop;
    if (match) begin
      next_flop = !output_flipflop; // see [RULE_04] [RULE_05]
    end else if (ctl_write && !running) begin
      next_flop = bus_req.wdata[CTL_PRESET_BIT] ^ phase; // see [RULE_12]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= 1'b0;
    end else if (ctrl.mode == MODE_TIMER) begin
      phase <= 1'b0; // see [RULE_13]
    end else if (match) begin
      phase <= !phase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      output_flipflop <= 1'b0; // see [RULE_09]
      pulse_output_pin <= 1'b1;
    end else begin
      output_flipflop <= next_flop;
      pulse_output_pin <= !next_flop; // see [RULE_08]
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_match_interrupt <= 1'b0;
    end else begin
      timer_match_interrupt <= match; // see [RULE_19]
    end
  end

  // A match in the same cycle as a write-one-to-clear keeps the bit set.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_status <= 1'b0;
    end else if (match) begin
      int_status <= 1'b1;
    end else if (hit(bus_req, ADDR_INT_STATUS) && bus_req.wdata[INT_MATCH_BIT]) begin
      int_status <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_mask <= 1'b0;
    end else if (hit(bus_req, ADDR_INT_MASK)) begin
      int_mask <= bus_req.wdata[INT_MATCH_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (int_status || match) && int_mask;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= RST_WORD;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CONTROL: rd_data <= {9'h000, ctrl};
        ADDR_PERIOD: rd_data <= period_compare;
        ADDR_DUTY: rd_data <= duty_compare;
        ADDR_COUNT: rd_data <= count;
        ADDR_INT_STATUS: rd_data <= {15'h0000, int_status};
        ADDR_INT_MASK: rd_data <= {15'h0000, int_mask};
        ADDR_STATE: rd_data <= {13'h0000, !running && ctrl.start[1] && ctrl.mode,
                                running, output_flipflop};
        default: rd_data <= RST_WORD;
      endcase
    end else begin
      rd_data <= RST_WORD;
    end
  end

endmodule : tpp_timer
`default_nettype wire

// >>> testbench/tpp_trigger_src.sv
// Trigger pin source that drives one high pulse of a chosen width on command.
`timescale 1ns/10ps
`default_nettype none
module tpp_trigger_src (
  input wire logic ref_clk, // Clock.
  input wire logic fire, // Start a pulse.
  input wire logic [7:0] width, // Pulse length in cycles.
  output logic trigger_input_pin // Trigger pin level.
);
  logic [7:0] left = 8'h00;
  // Widths of 4 and 12 cycles straddle the reject and detect limits.
  always @(posedge ref_clk) begin
    if (fire) begin
      left <= width;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign trigger_input_pin = left != 8'h00;
endmodule : tpp_trigger_src
`default_nettype wire

// >>> testbench/tpp_timer_sva.sv
// Port checker of the pulse timer.
`timescale 1ns/10ps
`default_nettype none
module tpp_timer_sva
  import tpp_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic reset, // Reset.
  input wire tpp_bus_req_t bus_req, // Register request.
  input wire logic [DATA_W-1:0] rd_data, // Read data.
  input wire logic trigger_input_pin, // Trigger pin.
  input wire logic pulse_output_pin, // Pulse pin.
  input wire logic timer_match_interrupt, // Match pulse.
  input wire logic irq // Level interrupt.
);
  logic stop_wr;
  logic [3:0] quiet;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A last match may still move the pin just after a stop write, while running drops a cycle late, so wait two cycles.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      quiet <= 4'h0;
      stop_wr <= 1'b0;
    end else if (bus_req.wr) begin
      quiet <= 4'h0;
      if (bus_req.addr == ADDR_CONTROL) begin
        stop_wr <= bus_req.wdata[1:0] == START_STOP;
      end
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  a_reset_vals: assert property (disable iff (1'b0) reset |=>
    pulse_output_pin && !timer_match_interrupt && !irq && rd_data == 16'h0000)
    else $error("bad output values after reset");
  // Back-to-back matches are legal at the fastest source clock, but each one toggles the pin.
  a_match_single: assert property (timer_match_interrupt |=>
    !timer_match_interrupt || $changed(pulse_output_pin))
    else $error("match pulse longer than one cycle");
  a_match_toggles: assert property (timer_match_interrupt |->
    $changed(pulse_output_pin)) else $error("match without pin toggle");
  a_pin_cause: assert property ($changed(pulse_output_pin) |-> timer_match_interrupt
    || $past(bus_req.wr) || $past(bus_req.wr, 2)) else $error("pin moved without cause");
  a_stop_hold: assert property (stop_wr && quiet >= 4'h2 |->
    $stable(pulse_output_pin) && !timer_match_interrupt) else $error("stopped timer moved");
  a_irq_rise: assert property ($rose(irq) |-> timer_match_interrupt
    || $past(bus_req.wr) || $past(bus_req.wr, 2)) else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq) |->
    $past(bus_req.wr) || $past(bus_req.wr, 2)) else $error("irq fell without a write");
  a_rd_idle: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000)
    else $error("read data outside its cycle");
  c_match_irq: cover property (timer_match_interrupt && irq);
  c_irq_clear: cover property ($fell(irq));
  c_stop_quiet: cover property (stop_wr && quiet == 4'hf);
endmodule : tpp_timer_sva
bind tpp_timer tpp_timer_sva tpp_timer_sva_inst (.ref_clk(ref_clk), .reset(reset),
  .bus_req(bus_req), .rd_data(rd_data), .trigger_input_pin(trigger_input_pin),
  .pulse_output_pin(pulse_output_pin), .timer_match_interrupt(timer_match_interrupt), .irq(irq));
`default_nettype wire

// >>> testbench/test_tpp_timer.sv
// Self-checking bench of the pulse timer.
`timescale 1ns/10ps
`default_nettype none
module test_tpp_timer
  import tpp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  tpp_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] rd_data;
  logic trigger_input_pin, pulse_output_pin, timer_match_interrupt, irq;
  logic fire = 1'b0;
  logic [7:0] width = 8'h00;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  int stamp[$];
  int miscompares = 0, n_compared = 0, cyc = 0, seed = 42, n_tmi = 0;
  logic [15:0] dv, pv;
  logic [3:0] ra[7] = '{ADDR_CONTROL, ADDR_PERIOD, ADDR_DUTY, ADDR_COUNT, ADDR_INT_STATUS,
    ADDR_INT_MASK, 4'h7};
  logic [15:0] rv[7] = '{RST_WORD, RST_COMPARE, RST_COMPARE, RST_WORD, RST_WORD, RST_WORD, RST_WORD};
  tpp_timer tpp_timer_inst (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .trigger_input_pin(trigger_input_pin), .pulse_output_pin(pulse_output_pin),
    .timer_match_interrupt(timer_match_interrupt), .irq(irq));
  tpp_trigger_src tpp_trigger_src_inst (.ref_clk(ref_clk), .fire(fire), .width(width),
    .trigger_input_pin(trigger_input_pin));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    exp_q.push_back({m, e});
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic trig(input logic [7:0] w);
    @(posedge ref_clk);
    fire <= 1'b1;
    width <= w;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : trig
  task automatic wait_tmi(input int k);
    int g;
    g = 0;
    while (n_tmi < k && g < 2000) begin
      @(posedge ref_clk);
      g++;
    end
    chk(16'(n_tmi), 16'(k));
  endtask : wait_tmi
  // Read data are compared two edges after the strobe, in the only cycle they stand.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (timer_match_interrupt === 1'b1) begin
      n_tmi <= n_tmi + 1;
      stamp.push_back(cyc);
    end
    if (rd_seen === 1'b1) begin
      chk(rd_data & exp_q[0][31:16], exp_q[0][15:0]);
      exp_q.delete(0);
    end
    rd_seen <= bus_req.rd;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    dv = 16'(2 + {$random(seed)} % 8);
    pv = dv + 16'(8 + {$random(seed)} % 8);
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    chk(16'(pulse_output_pin), 16'h1);
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    wr(ADDR_CONTROL, 16'h0010);
    wr(ADDR_PERIOD, pv);
    wr(ADDR_DUTY, dv);
    wr(ADDR_INT_MASK, 16'h0001);
    wr(ADDR_CONTROL, 16'h0011);
    wait_tmi(3);
    wr(ADDR_CONTROL, 16'h0010);
    chk(16'(stamp[1] - stamp[0]), pv - dv);
    chk(16'(stamp[2] - stamp[1]), dv + 16'h1);
    chk(16'(pulse_output_pin), 16'h0);
    chk(16'(irq), 16'h1);
    idle(30);
    chk(16'(n_tmi), 16'h3);
    rd(ADDR_STATE, 16'h0001, 16'h0003);
    wr(ADDR_CONTROL, 16'h0010);
    idle(3);
    chk(16'(pulse_output_pin), 16'h0);
    wr(ADDR_CONTROL, 16'h0018);
    idle(3);
    chk(16'(pulse_output_pin), 16'h1);
    rd(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0001);
    rd(ADDR_INT_STATUS, 16'h0000);
    chk(16'(irq), 16'h0);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h0018);
    idle(3);
    chk(16'(pulse_output_pin), 16'h0);
    wr(ADDR_INT_MASK, 16'h0000);
    wr(ADDR_CONTROL, 16'h003d);
    wait_tmi(5);
    idle(300);
    chk(16'(n_tmi), 16'h5);
    chk(16'(stamp[4] - stamp[3]), (pv - dv) * 16'h8);
    rd(ADDR_CONTROL, 16'h003c);
    chk(16'(pulse_output_pin), 16'h0);
    chk(16'(irq), 16'h0);
    rd(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h001e);
    trig(8'h04);
    idle(20);
    chk(16'(n_tmi), 16'h5);
    rd(ADDR_STATE, 16'h0004, 16'h0006);
    trig(8'h0c);
    wait_tmi(7);
    idle(40);
    rd(ADDR_CONTROL, 16'h0000, 16'h0003);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h001f);
    trig(8'h50);
    idle(60);
    chk(16'(n_tmi), 16'h7);
    wait_tmi(9);
    // The two slow source clocks, one one-shot pulse each, timed between the two matches.
    for (int s = 2; s < 4; s++) begin
      wr(ADDR_CONTROL, 16'h0000);
      wr(ADDR_CONTROL, 16'h0015 | 16'(s << CTL_CLK_LSB));
      wait_tmi(2 * s + 6);
      wait_tmi(2 * s + 7);
      chk(16'(stamp[2 * s + 6] - stamp[2 * s + 5]),
        (pv - dv) * (s == 2 ? 16'h0020 : 16'h0080));
    end
    idle(4);
    test_done();
  end
endmodule : test_tpp_timer
`default_nettype wire
